// File: design/ipr_pkg.sv
// package for the interrupt priority register bank
package ipr_pkg;

  // source count and bank shape
  localparam int NSRC = 15;
  localparam int NREG = 8;
  localparam int PW = 3;

  // register indices used by the decoder
  localparam logic [3:0] IDX_ADC_UART_TX = 4'h0;
  localparam logic [3:0] IDX_CN_I2C = 4'h1;
  localparam logic [3:0] IDX_CAPTURE_EXT1 = 4'h2;
  localparam logic [3:0] IDX_EXT2 = 4'h3;
  localparam logic [3:0] IDX_ENC_PWM1 = 4'h4;
  localparam logic [3:0] IDX_PWM1_FAULT = 4'h5;
  localparam logic [3:0] IDX_UART_ERR = 4'h6;
  localparam logic [3:0] IDX_PWM2_FAULT = 4'h7;
  localparam logic [3:0] IDX_ENABLE = 4'h8;
  localparam logic [3:0] IDX_PENDING = 4'h9;
  localparam logic [3:0] IDX_NONE = 4'hf;

  // byte offsets on the bus
  localparam logic [7:0] OFF_PRIO_ADC_UART_TX = 8'h00;
  localparam logic [7:0] OFF_PRIO_CHANGE_NOTIFY_I2C = 8'h04;
  localparam logic [7:0] OFF_PRIO_CAPTURE_EXT1 = 8'h08;
  localparam logic [7:0] OFF_PRIO_EXT2 = 8'h0c;
  localparam logic [7:0] OFF_PRIO_ENCODER_PWM1 = 8'h10;
  localparam logic [7:0] OFF_PRIO_PWM1_FAULT = 8'h14;
  localparam logic [7:0] OFF_PRIO_UART_ERROR = 8'h18;
  localparam logic [7:0] OFF_PRIO_PWM2_AND_FAULT = 8'h1c;
  localparam logic [7:0] OFF_ENABLE = 8'h20;
  localparam logic [7:0] OFF_PENDING = 8'h24;

  // reset values of a priority field and of the enable word
  localparam logic [2:0] PRIO_RST = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [14:0] ENABLE_RST = 15'h0000;

  // source order: adc, uart tx, cn, i2c m, i2c s, cap8, cap7, ext1,
  // ext2, encoder, pwm a, pwm a fault, uart err, pwm b fault, pwm b
  localparam logic [3:0] SRC_REG [NSRC] = '{
    4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2,
    4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7};
  localparam int SRC_LSB [NSRC] = '{
    4, 0, 12, 4, 0, 12, 8, 0, 4, 8, 4, 12, 4, 8, 4};
  localparam logic [2:0] SRC_RST [NSRC] = '{
    PRIO_RST, PRIO_RST, PRIO_RST, PRIO_RST, PRIO_RST, PRIO_RST,
    PRIO_RST, PRIO_RST, PRIO_RST, PRIO_RST, PRIO_RST, PRIO_RST,
    PRIO_RST, PRIO_OFF, PRIO_RST};

  // priority levels handed to the arbiter
  typedef struct packed {
    logic [2:0] adc_done_priority;
    logic [2:0] uart_tx_priority;
    logic [2:0] change_notify_priority;
    logic [2:0] i2c_master_priority;
    logic [2:0] i2c_slave_priority;
    logic [2:0] capture_ch8_priority;
    logic [2:0] capture_ch7_priority;
    logic [2:0] ext_irq1_priority;
    logic [2:0] ext_irq2_priority;
    logic [2:0] encoder_priority;
    logic [2:0] pwm_a_priority;
    logic [2:0] pwm_a_fault_priority;
    logic [2:0] uart_error_priority;
    logic [2:0] pwm_b_fault_priority;
    logic [2:0] pwm_b_priority;
  } ipr_prio_s;

endpackage

// File: design/ipr_bank.sv
// interrupt priority register bank with apb slave and request gating
`timescale 1ns/1ps

// Contract
// RULE1 - field is three bits; 111 means level 7, the highest
// RULE2 - field 001 means level 1; codes between map to levels 2..6
// RULE3 - field 000 disables the source; it never raises a request
// RULE4 - unimplemented bits read zero and ignore writes
// RULE5 - reset loads 100 into every field except pwm b fault
// RULE6 - pwm b fault field at bits 10..8 resets to 000
// RULE7 - adc done at bits 6..4, uart tx at bits 2..0
// RULE8 - change notify 14..12, i2c master 6..4, i2c slave 2..0
// RULE9 - capture 8 at 14..12, capture 7 at 10..8, ext irq 1 at 2..0
// RULE10 - ext irq 2 at bits 6..4, all else unimplemented
// RULE11 - encoder at bits 10..8 and pwm a at bits 6..4
// RULE12 - pwm a fault at bits 14..12, bits 11..0 unimplemented
// RULE13 - uart error at bits 6..4, all else unimplemented
// RULE14 - pwm b at bits 6..4 beside pwm b fault, resets to 4
// RULE15 - reset leaves every other source at level 4
// RULE16 - request only while the source enable bit is set
// RULE17 - levels go out continuously; writes act next cycle
module ipr_bank #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // source flags from peripherals
  input wire logic [14:0] IRQ_FLAG,
  // toward the arbiter
  output ipr_pkg::ipr_prio_s PRIO,
  output logic [14:0] IRQ_REQ
);

  // the decoder needs all ten word offsets; refused at elaboration
  if (ADDR_W < 6) begin : g_addr_too_small
    $error("ADDR_W too small for the register map");
  end

  logic [2:0] prio_q [ipr_pkg::NSRC];
  logic [14:0] en_q;
  logic [14:0] req_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic [3:0] sel;
  logic wr_fire;
  logic setup;

  // map a byte address to a register index
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = 8'(a);
    if (ADDR_W > 8 && (a >> 8) != '0) begin
      return ipr_pkg::IDX_NONE;
    end
    case (w)
      ipr_pkg::OFF_PRIO_ADC_UART_TX: return ipr_pkg::IDX_ADC_UART_TX;
      ipr_pkg::OFF_PRIO_CHANGE_NOTIFY_I2C: return ipr_pkg::IDX_CN_I2C;
      ipr_pkg::OFF_PRIO_CAPTURE_EXT1: return ipr_pkg::IDX_CAPTURE_EXT1;
      ipr_pkg::OFF_PRIO_EXT2: return ipr_pkg::IDX_EXT2;
      ipr_pkg::OFF_PRIO_ENCODER_PWM1: return ipr_pkg::IDX_ENC_PWM1;
      ipr_pkg::OFF_PRIO_PWM1_FAULT: return ipr_pkg::IDX_PWM1_FAULT;
      ipr_pkg::OFF_PRIO_UART_ERROR: return ipr_pkg::IDX_UART_ERR;
      ipr_pkg::OFF_PRIO_PWM2_AND_FAULT: return ipr_pkg::IDX_PWM2_FAULT;
      ipr_pkg::OFF_ENABLE: return ipr_pkg::IDX_ENABLE;
      ipr_pkg::OFF_PENDING: return ipr_pkg::IDX_PENDING;
      default: return ipr_pkg::IDX_NONE;
    endcase
  endfunction

  // implemented bits of a priority, enable or pending register
  function automatic logic [31:0] impl_mask(input logic [3:0] idx);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int s = 0; s < ipr_pkg::NSRC; s++) begin
      if (ipr_pkg::SRC_REG[s] == idx) begin
        m[ipr_pkg::SRC_LSB[s] +: 3] = 3'h7;
      end
    end
    if (idx == ipr_pkg::IDX_ENABLE || idx == ipr_pkg::IDX_PENDING) begin
      m = 32'h0000_7fff;
    end
    return m;
  endfunction

  // bus phase decode; zero wait states
  assign sel = decode(PADDR);
  assign setup = PSEL && !PENABLE;
  assign wr_fire = PSEL && PENABLE && PWRITE && sel != ipr_pkg::IDX_NONE;
  assign PREADY = 1'b1;
  // unmapped offsets finish with an error, nothing stored
  assign PSLVERR = PSEL && PENABLE && sel == ipr_pkg::IDX_NONE;
  assign PRDATA = prdata_q;

  // priority fields; the byte lane holding a field must be strobed
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int s = 0; s < ipr_pkg::NSRC; s++) begin
        // RULE5 reset to four
        // RULE6 pwm b fault off
        // RULE15 others at four
        prio_q[s] <= ipr_pkg::SRC_RST[s];
      end
    end else begin
      for (int s = 0; s < ipr_pkg::NSRC; s++) begin
        // RULE1 three bit level
        // RULE2 code is level
        // RULE17 write lands next edge
        // RULE4 only field bits stored
        if (wr_fire && sel == ipr_pkg::SRC_REG[s]
            && PSTRB[ipr_pkg::SRC_LSB[s] / 8]) begin
          prio_q[s] <= PWDATA[ipr_pkg::SRC_LSB[s] +: 3];
        end
      end
    end
  end

  // enable bits, one per source in source order
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      en_q <= ipr_pkg::ENABLE_RST;
    end else if (wr_fire && sel == ipr_pkg::IDX_ENABLE) begin
      if (PSTRB[0]) begin
        en_q[7:0] <= PWDATA[7:0];
      end
      if (PSTRB[1]) begin
        en_q[14:8] <= PWDATA[14:8];
      end
    end
  end

  // request gating; registered so the arbiter sees clean levels
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      req_q <= 15'h0000;
    end else begin
      for (int s = 0; s < ipr_pkg::NSRC; s++) begin
        // RULE3 level zero blocks
        // RULE16 enable gates request
        req_q[s] <= IRQ_FLAG[s] && en_q[s] && prio_q[s] != 3'h0;
      end
    end
  end
  assign IRQ_REQ = req_q;

  // read word assembly; unimplemented bits stay zero
  always_comb begin
    rd_d = 32'h0000_0000;
    for (int s = 0; s < ipr_pkg::NSRC; s++) begin
      // RULE4 reserved read zero
      if (ipr_pkg::SRC_REG[s] == sel) begin
        rd_d[ipr_pkg::SRC_LSB[s] +: 3] = prio_q[s];
      end
    end
    if (sel == ipr_pkg::IDX_ENABLE) begin
      rd_d[14:0] = en_q;
    end
    if (sel == ipr_pkg::IDX_PENDING) begin
      rd_d[14:0] = req_q;
    end
  end

  // capture read data in the setup phase; no write can intervene
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      prdata_q <= rd_d;
    end
  end

  // field layout out to the arbiter, held straight from the flops
  // RULE7 adc and uart tx
  assign PRIO.adc_done_priority = prio_q[0];
  assign PRIO.uart_tx_priority = prio_q[1];
  // RULE8 cn and i2c
  assign PRIO.change_notify_priority = prio_q[2];
  assign PRIO.i2c_master_priority = prio_q[3];
  assign PRIO.i2c_slave_priority = prio_q[4];
  // RULE9 captures and ext1
  assign PRIO.capture_ch8_priority = prio_q[5];
  assign PRIO.capture_ch7_priority = prio_q[6];
  assign PRIO.ext_irq1_priority = prio_q[7];
  // RULE10 ext2 alone
  assign PRIO.ext_irq2_priority = prio_q[8];
  // RULE11 encoder and pwm a
  assign PRIO.encoder_priority = prio_q[9];
  assign PRIO.pwm_a_priority = prio_q[10];
  // RULE12 pwm a fault
  assign PRIO.pwm_a_fault_priority = prio_q[11];
  // RULE13 uart error
  assign PRIO.uart_error_priority = prio_q[12];
  // RULE14 pwm b pair
  assign PRIO.pwm_b_fault_priority = prio_q[13];
  assign PRIO.pwm_b_priority = prio_q[14];

  // checks on the bank's own behaviour

  property p_level_seven;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_ADC_UART_TX && PSTRB[0]
     && PWDATA[6:4] == 3'h7) |=> PRIO.adc_done_priority == 3'h7;
  endproperty
  a_level_seven: assert property (p_level_seven) // RULE1
    else $error("level 7 write not held");

  property p_level_one;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_ADC_UART_TX && PSTRB[0]
     && PWDATA[2:0] == 3'h1) |=> PRIO.uart_tx_priority == 3'h1;
  endproperty
  a_level_one: assert property (p_level_one) // RULE2
    else $error("level 1 write not held");

  property p_zero_blocks;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (prio_q[0] == 3'h0) |=> !IRQ_REQ[0];
  endproperty
  a_zero_blocks: assert property (p_zero_blocks) // RULE3
    else $error("disabled source raised a request");

  property p_reserved_zero;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (PSEL && PENABLE && !PWRITE)
      |-> (PRDATA & ~impl_mask(sel)) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE4
    else $error("unimplemented bits read nonzero");

  property p_reset_four;
    @(posedge CLK_SYS) disable iff (!RSTN)
    $rose(RSTN) |-> PRIO.adc_done_priority == ipr_pkg::PRIO_RST
      && PRIO.pwm_b_priority == ipr_pkg::PRIO_RST;
  endproperty
  a_reset_four: assert property (p_reset_four) // RULE5
    else $error("field not at level 4 after reset");

  property p_fault_b_off;
    @(posedge CLK_SYS) disable iff (!RSTN)
    $rose(RSTN) |-> PRIO.pwm_b_fault_priority == ipr_pkg::PRIO_OFF
      && IRQ_REQ == 15'h0000;
  endproperty
  a_fault_b_off: assert property (p_fault_b_off) // RULE6
    else $error("pwm b fault not off after reset");

  property p_enable_gates;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (!en_q[14]) |=> !IRQ_REQ[14];
  endproperty
  a_enable_gates: assert property (p_enable_gates) // RULE16
    else $error("request without enable");

  property p_request_follows;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (IRQ_FLAG[7] && en_q[7] && prio_q[7] != 3'h0) |=> IRQ_REQ[7];
  endproperty
  a_request_follows: assert property (p_request_follows) // RULE16
    else $error("enabled request not raised");

  property p_write_next;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_PWM2_FAULT && PSTRB[1])
      |=> PRIO.pwm_b_fault_priority == $past(PWDATA[10:8]);
  endproperty
  a_write_next: assert property (p_write_next) // RULE17
    else $error("write not visible next cycle");

  property p_no_write_hold;
    @(posedge CLK_SYS) disable iff (!RSTN)
    !(wr_fire && sel == ipr_pkg::IDX_CAPTURE_EXT1)
      |=> $stable(PRIO.capture_ch8_priority);
  endproperty
  a_no_write_hold: assert property (p_no_write_hold) // RULE9
    else $error("field changed without a write");

  // field placement checks for fields the other checks leave open; ext irq 1, pwm a and capture 8 stay unchecked
  property p_adc_tx_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_ADC_UART_TX && PSTRB[0])
      |=> PRIO.uart_tx_priority == $past(PWDATA[2:0]);
  endproperty
  a_adc_tx_place: assert property (p_adc_tx_place) // RULE7
    else $error("uart tx field not at bits 2..0");

  property p_cn_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_CN_I2C && PSTRB[1])
      |=> PRIO.change_notify_priority == $past(PWDATA[14:12]);
  endproperty
  a_cn_place: assert property (p_cn_place) // RULE8
    else $error("change notify field not at bits 14..12");

  property p_i2c_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_CN_I2C && PSTRB[0])
      |=> PRIO.i2c_master_priority == $past(PWDATA[6:4])
      && PRIO.i2c_slave_priority == $past(PWDATA[2:0]);
  endproperty
  a_i2c_place: assert property (p_i2c_place) // RULE8
    else $error("i2c fields misplaced");

  property p_capture_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_CAPTURE_EXT1 && PSTRB[1])
      |=> PRIO.capture_ch7_priority == $past(PWDATA[10:8]);
  endproperty
  a_capture_place: assert property (p_capture_place) // RULE9
    else $error("capture 7 field not at bits 10..8");

  property p_ext2_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_EXT2 && PSTRB[0])
      |=> PRIO.ext_irq2_priority == $past(PWDATA[6:4]);
  endproperty
  a_ext2_place: assert property (p_ext2_place) // RULE10
    else $error("ext irq 2 field not at bits 6..4");

  property p_enc_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_ENC_PWM1 && PSTRB[1])
      |=> PRIO.encoder_priority == $past(PWDATA[10:8]);
  endproperty
  a_enc_place: assert property (p_enc_place) // RULE11
    else $error("encoder field not at bits 10..8");

  property p_fault_a_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_PWM1_FAULT && PSTRB[1])
      |=> PRIO.pwm_a_fault_priority == $past(PWDATA[14:12]);
  endproperty
  a_fault_a_place: assert property (p_fault_a_place) // RULE12
    else $error("pwm a fault field not at bits 14..12");

  property p_uart_err_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_UART_ERR && PSTRB[0])
      |=> PRIO.uart_error_priority == $past(PWDATA[6:4]);
  endproperty
  a_uart_err_place: assert property (p_uart_err_place) // RULE13
    else $error("uart error field not at bits 6..4");

  property p_pwm_b_place;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_fire && sel == ipr_pkg::IDX_PWM2_FAULT && PSTRB[0])
      |=> PRIO.pwm_b_priority == $past(PWDATA[6:4]);
  endproperty
  a_pwm_b_place: assert property (p_pwm_b_place) // RULE14
    else $error("pwm b field not at bits 6..4");

  property p_reset_others;
    @(posedge CLK_SYS) disable iff (!RSTN)
    $rose(RSTN) |-> PRIO.encoder_priority == ipr_pkg::PRIO_RST
      && PRIO.uart_error_priority == ipr_pkg::PRIO_RST
      && PRIO.ext_irq2_priority == ipr_pkg::PRIO_RST;
  endproperty
  a_reset_others: assert property (p_reset_others) // RULE15
    else $error("source not at level 4 after reset");

  property p_fault_b_quiet;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (prio_q[13] == 3'h0) |=> !IRQ_REQ[13];
  endproperty
  a_fault_b_quiet: assert property (p_fault_b_quiet) // RULE3
    else $error("disabled pwm b fault raised a request");

endmodule

// File: test/tb_interrupt_priority_registers.sv
// self-checking bench for the interrupt priority register bank
`timescale 1ns/1ps
module tb_interrupt_priority_registers;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [14:0] irq_flag, irq_req;
  ipr_pkg::ipr_prio_s prio;
  int failures, checks_done;
  logic [15:0] lfsr_q;
  // model words: eight priority words, then the enable word
  logic [15:0] mdl [9];
  localparam logic [15:0] WMASK [9] = '{16'h0077, 16'h7077, 16'h7707,
    16'h0070, 16'h0770, 16'h7000, 16'h0070, 16'h0770, 16'h7fff};
  localparam logic [15:0] RVAL [9] = '{16'h0044, 16'h4044, 16'h4404,
    16'h0040, 16'h0440, 16'h4000, 16'h0040, 16'h0040, 16'h0000};
  // word and low bit of each source field, in source order
  localparam int SREG [15] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 4, 4, 5, 6, 7, 7};
  localparam int SLSB [15] = '{4, 0, 12, 4, 0, 12, 8, 0, 4, 8, 4, 12, 4, 8,
    4};

  ipr_bank #(.ADDR_W(8)) i_dut (
    .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ_FLAG(irq_flag), .PRIO(prio), .IRQ_REQ(irq_req));

  // 25 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [44:0] prio_exp();
    logic [44:0] v;
    v = '0;
    for (int s = 0; s < 15; s++) begin
      v[(14 - s) * 3 +: 3] = mdl[SREG[s]][SLSB[s] +: 3];
    end
    return v;
  endfunction

  // a zero level blocks the source as hard as a clear enable
  function automatic logic [14:0] req_exp();
    logic [14:0] v;
    v = '0;
    for (int s = 0; s < 15; s++) begin
      v[s] = irq_flag[s] & mdl[8][s] & (mdl[SREG[s]][SLSB[s] +: 3] != 3'h0);
    end
    return v;
  endfunction

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] r,
      output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic e;
    logic [15:0] m;
    apb(1'b1, 8'(i * 4), d, s, r, e);
    if (i < 9) begin
      m = {{8{s[1]}}, {8{s[0]}}} & WMASK[i];
      mdl[i] = (mdl[i] & ~m) | (d[15:0] & m);
    end
    chk(e, i > 9);
    chk(prio, prio_exp());
  endtask

  task automatic rd(input int i);
    logic [31:0] r, x;
    logic e;
    apb(1'b0, 8'(i * 4), 32'h0, 4'h0, r, e);
    x = (i < 9) ? {16'h0, mdl[i]} : (i == 9) ? {17'h0, req_exp()} : 32'h0;
    chk(r, x);
    chk(e, i > 9);
    chk(prio, prio_exp());
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    mdl = RVAL;
    @(posedge clk_sys);
  endtask

  initial begin
    logic [15:0] v, d;
    failures = 0;
    checks_done = 0;
    lfsr_q = 16'd11501;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    irq_flag = 15'h0;
    mdl = RVAL;
    do_reset();
    for (int i = 0; i < 11; i++) rd(i);
    rd(63);
    $display("test reset values done");
    for (int i = 0; i < 11; i++) begin
      wr(i, 32'hffffffff, 4'hf);
      rd(i);
    end
    $display("test field layout done");
    for (int k = 0; k < 200; k++) begin
      v = rnd();
      d = rnd();
      wr(int'(v[3:0]) % 11, {d, d}, v[7:4]);
      irq_flag <= d[14:0] ^ v[14:0];
      @(posedge clk_sys);
      #1;
      chk(irq_req, req_exp());
      @(posedge clk_sys);
      rd(int'(d[3:0]) % 11);
    end
    $display("test random traffic done");
    // zero level blocks every flagged source
    wr(8, 32'h7fff, 4'hf);
    irq_flag <= 15'h7fff;
    for (int i = 0; i < 8; i++) wr(i, 32'hffff, 4'h3);
    rd(9);
    for (int i = 0; i < 8; i++) wr(i, 32'h0, 4'h3);
    rd(9);
    $display("test disabled sources done");
    do_reset();
    for (int i = 0; i < 10; i++) rd(i);
    $display("test second reset done");
    wrap_up();
  end
endmodule
